// *** design/dct_pkg.sv ***
package dct_pkg;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] IDX_CMP_A_HIGH     = 4'h0;
  localparam logic [3:0] IDX_CMP_A_LOW      = 4'h1;
  localparam logic [3:0] IDX_CMP_B_HIGH     = 4'h2;
  localparam logic [3:0] IDX_CMP_B_LOW      = 4'h3;
  localparam logic [3:0] IDX_FIFO_HIGH      = 4'h4;
  localparam logic [3:0] IDX_FIFO_LOW       = 4'h5;
  localparam logic [3:0] IDX_TRACE_CONTROL  = 4'h6;
  localparam logic [3:0] IDX_FORCE_RESET    = 4'h9;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_ENABLE      = 7;
  localparam int BIT_ARM         = 6;
  localparam int BIT_TAG         = 5;
  localparam int BIT_BRK_EN      = 4;
  localparam int BIT_A_DIR_VAL   = 3;
  localparam int BIT_A_DIR_EN    = 2;
  localparam int BIT_B_DIR_VAL   = 1;
  localparam int BIT_B_DIR_EN    = 0;
  localparam int BIT_FORCE_RESET = 0;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [3:0]  FIFO_FULL   = 4'h8;
  localparam int          BUF_ENTRIES = 2;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] sel;
    logic       wr;
    logic       rd;
    logic       from_debug;
    logic [7:0] wdata;
  } dct_bus_req_s;

  typedef struct packed {
    logic        valid;
    logic        read;
    logic [15:0] addr;
    logic [7:0]  data;
  } dct_mon_s;

endpackage : dct_pkg

// *** design/dct_regs.sv ***
// Function
// - Force-reset register always reads zero.
// - Force-reset writes from CPU programs are ignored; only debug-path writes act.
// - Debug-path write of one to bit 0 starts a full system reset.
// - Four comparator bytes reset to zero and are always readable.
// - Comparator byte writes are blocked while arm is one.
// - Eight bytes: two comparators, FIFO window, two control and status registers.
// - FIFO high byte reads upper byte of current word; writes do nothing.
// - Event-only modes store only low bytes; high byte reads zero.
// - Reading FIFO high byte leaves the read position unchanged.
// - Reading FIFO low byte returns low byte then advances; writes ignored.
// - Low-byte reads while armed do not advance the FIFO.
// - Low-byte read while unarmed stores last opcode address into last slot.
// - Profiling: FIFO is an eight-deep delay line; ninth read returns first.
// - Control register is readable and writable at all times.
// - Enable bit cannot become one while the device is secured.
// - Arm write with enable bit one sets arm and flag; run end clears; zero write stops.
// - Bit 5 picks force or tag break; ignored when break enable is zero.
// - Break on trigger in end trace, on FIFO full in begin trace.
// - Comparator A direction qualified by bit 3 when bit 2 is set.
// - Comparator B direction qualified by bit 1 when bit 0 is set.
// - Run ends on full FIFO in begin trace or trigger in end trace.
`timescale 1ns/1ps
`default_nettype none

module dct_regs (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire dct_pkg::dct_bus_req_s bus_req,
  output logic [7:0]                rdata,
  input  wire dct_pkg::dct_mon_s    mon,
  output logic                      mon_ready,
  input  wire logic [15:0]          opcode_addr,
  input  wire logic                 secured,
  input  wire logic                 event_only_mode,
  input  wire logic                 begin_trace,
  output logic                      force_reset,
  output logic                      break_req,
  output logic                      break_tag,
  output logic                      arm_flag,
  output logic [3:0]                fifo_count
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  cmp_a_high;
  logic [7:0]  cmp_a_low;
  logic [7:0]  cmp_b_high;
  logic [7:0]  cmp_b_low;
  logic [7:0]  trace_control;
  logic [15:0] fifo_mem [dct_pkg::FIFO_DEPTH];
  logic [15:0] buf_mem [dct_pkg::BUF_ENTRIES];
  logic [1:0]  buf_cnt;
  logic        triggered;

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic hit(input logic [3:0] sel, input logic [3:0] idx);
    hit = (sel == idx);
  endfunction : hit

  function automatic logic dir_ok(input logic en, input logic val, input logic rd);
    dir_ok = !en || (val == rd);
  endfunction : dir_ok

  logic armed;
  logic wr_ctrl;
  logic wr_cmp_ok;
  logic lo_read;
  logic match_a;
  logic match_b;
  logic trig;
  logic buf_in_valid;
  logic buf_out_valid;
  logic buf_out_ready;
  logic buf_push;
  logic buf_pop;
  logic store;
  logic run_end;
  logic arm_start;
  logic [15:0] cap_word;

  assign armed     = trace_control[dct_pkg::BIT_ARM];
  assign wr_ctrl   = bus_req.wr && hit(bus_req.sel, dct_pkg::IDX_TRACE_CONTROL);
  assign wr_cmp_ok = bus_req.wr && !armed;
  assign lo_read   = bus_req.rd && hit(bus_req.sel, dct_pkg::IDX_FIFO_LOW);
  assign arm_start = wr_ctrl && bus_req.wdata[dct_pkg::BIT_ARM] && !armed
                     && bus_req.wdata[dct_pkg::BIT_ENABLE]
                     && (trace_control[dct_pkg::BIT_ENABLE] || !secured);

  // ****************************************
  // Comparators
  // ****************************************
  assign match_a = mon.valid && (mon.addr == {cmp_a_high, cmp_a_low})
                   && dir_ok(trace_control[dct_pkg::BIT_A_DIR_EN],
                             trace_control[dct_pkg::BIT_A_DIR_VAL], mon.read);
  assign match_b = mon.valid && (mon.addr == {cmp_b_high, cmp_b_low})
                   && dir_ok(trace_control[dct_pkg::BIT_B_DIR_EN],
                             trace_control[dct_pkg::BIT_B_DIR_VAL], mon.read);
  assign trig    = armed && match_a;
  assign cap_word = event_only_mode ? {dct_pkg::RST_BYTE, mon.data} : mon.addr;

  // ****************************************
  // Two-entry capture buffer
  // ****************************************
  assign buf_in_valid  = armed && (match_a || match_b);
  assign mon_ready     = (buf_cnt != 2'd2);
  assign buf_out_valid = (buf_cnt != 2'd0);
  assign buf_out_ready = !lo_read;
  assign buf_push      = buf_in_valid && mon_ready;
  assign buf_pop       = buf_out_valid && buf_out_ready;
  assign store = buf_pop && armed && (!begin_trace || triggered || trig)
                 && !(begin_trace && fifo_count == dct_pkg::FIFO_FULL);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      buf_cnt    <= 2'd0;
      buf_mem[0] <= dct_pkg::RST_WORD;
      buf_mem[1] <= dct_pkg::RST_WORD;
    end else begin
      case ({buf_push, buf_pop})
        2'b10: begin
          if (buf_cnt == 2'd0) begin
            buf_mem[0] <= cap_word;
          end else begin
            buf_mem[1] <= cap_word;
          end
          buf_cnt <= buf_cnt + 2'd1;
        end
        2'b01: begin
          buf_mem[0] <= buf_mem[1];
          buf_cnt    <= buf_cnt - 2'd1;
        end
        2'b11: begin
          buf_mem[0] <= cap_word;
        end
        default: begin
          buf_cnt <= buf_cnt;
        end
      endcase
    end
  end

  // ****************************************
  // Comparator registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cmp_a_high <= dct_pkg::RST_BYTE;
      cmp_a_low  <= dct_pkg::RST_BYTE;
      cmp_b_high <= dct_pkg::RST_BYTE;
      cmp_b_low  <= dct_pkg::RST_BYTE;
    end else if (wr_cmp_ok) begin
      if (hit(bus_req.sel, dct_pkg::IDX_CMP_A_HIGH)) begin
        cmp_a_high <= bus_req.wdata;
      end else if (hit(bus_req.sel, dct_pkg::IDX_CMP_A_LOW)) begin
        cmp_a_low <= bus_req.wdata;
      end else if (hit(bus_req.sel, dct_pkg::IDX_CMP_B_HIGH)) begin
        cmp_b_high <= bus_req.wdata;
      end else if (hit(bus_req.sel, dct_pkg::IDX_CMP_B_LOW)) begin
        cmp_b_low <= bus_req.wdata;
      end
    end
  end

  // ****************************************
  // Control register and run state
  // ****************************************
  assign run_end = armed && ((!begin_trace && trig)
                   || (begin_trace && store
                       && fifo_count == dct_pkg::FIFO_FULL - 4'd1));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      trace_control <= dct_pkg::RST_BYTE;
    end else if (wr_ctrl) begin
      trace_control <= bus_req.wdata;
      trace_control[dct_pkg::BIT_ENABLE] <= bus_req.wdata[dct_pkg::BIT_ENABLE]
        && (trace_control[dct_pkg::BIT_ENABLE] || !secured);
      trace_control[dct_pkg::BIT_ARM] <= bus_req.wdata[dct_pkg::BIT_ARM]
        && bus_req.wdata[dct_pkg::BIT_ENABLE]
        && (trace_control[dct_pkg::BIT_ENABLE] || !secured);
    end else if (run_end) begin
      trace_control[dct_pkg::BIT_ARM] <= 1'b0;
    end
  end

  assign arm_flag = armed && trace_control[dct_pkg::BIT_ENABLE];

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      triggered <= 1'b0;
    end else if (arm_start || !armed) begin
      triggered <= 1'b0;
    end else if (trig) begin
      triggered <= 1'b1;
    end
  end

  // ****************************************
  // Trace FIFO
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < dct_pkg::FIFO_DEPTH; i++) begin
        fifo_mem[i] <= dct_pkg::RST_WORD;
      end
    end else if ((lo_read && !armed) || store) begin
      for (int i = 0; i < dct_pkg::FIFO_DEPTH - 1; i++) begin
        fifo_mem[i] <= fifo_mem[i + 1];
      end
      fifo_mem[dct_pkg::FIFO_DEPTH - 1] <= store ? buf_mem[0] : opcode_addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fifo_count <= 4'h0;
    end else if (arm_start) begin
      fifo_count <= 4'h0;
    end else if (store && fifo_count != dct_pkg::FIFO_FULL) begin
      fifo_count <= fifo_count + 4'h1;
    end
  end

  // ****************************************
  // Break requests
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      break_req <= 1'b0;
      break_tag <= 1'b0;
    end else begin
      break_req <= trace_control[dct_pkg::BIT_BRK_EN] && run_end;
      break_tag <= trace_control[dct_pkg::BIT_BRK_EN]
                   && trace_control[dct_pkg::BIT_TAG];
    end
  end

  // ****************************************
  // Force reset
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      force_reset <= 1'b0;
    end else begin
      force_reset <= bus_req.wr && bus_req.from_debug
                     && hit(bus_req.sel, dct_pkg::IDX_FORCE_RESET)
                     && bus_req.wdata[dct_pkg::BIT_FORCE_RESET];
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata <= dct_pkg::RST_BYTE;
    end else if (!bus_req.rd) begin
      rdata <= rdata;
    end else if (hit(bus_req.sel, dct_pkg::IDX_CMP_A_HIGH)) begin
      rdata <= cmp_a_high;
    end else if (hit(bus_req.sel, dct_pkg::IDX_CMP_A_LOW)) begin
      rdata <= cmp_a_low;
    end else if (hit(bus_req.sel, dct_pkg::IDX_CMP_B_HIGH)) begin
      rdata <= cmp_b_high;
    end else if (hit(bus_req.sel, dct_pkg::IDX_CMP_B_LOW)) begin
      rdata <= cmp_b_low;
    end else if (hit(bus_req.sel, dct_pkg::IDX_FIFO_HIGH)) begin
      rdata <= event_only_mode ? dct_pkg::RST_BYTE : fifo_mem[0][15:8];
    end else if (hit(bus_req.sel, dct_pkg::IDX_FIFO_LOW)) begin
      rdata <= fifo_mem[0][7:0];
    end else if (hit(bus_req.sel, dct_pkg::IDX_TRACE_CONTROL)) begin
      rdata <= trace_control;
    end else begin
      rdata <= dct_pkg::RST_BYTE;
    end
  end

endmodule : dct_regs

`default_nettype wire

// *** verification/dct_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module dct_regs_monitor (
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  input wire dct_pkg::dct_bus_req_s bus_req,
  input wire logic [7:0]            rdata,
  input wire logic                  secured,
  input wire logic                  begin_trace,
  input wire logic                  force_reset,
  input wire logic                  break_req,
  input wire logic                  arm_flag,
  input wire logic [3:0]            fifo_count
);
  // ****************************************
  // Register bus and run checks
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic frc;
  logic ctl;
  assign frc = bus_req.sel == dct_pkg::IDX_FORCE_RESET;
  assign ctl = bus_req.wr && bus_req.sel == dct_pkg::IDX_TRACE_CONTROL;

  AST_FRC_ZERO: assert property (bus_req.rd && frc |=> rdata == 8'h00)
    else $error("force reset register read nonzero");
  AST_FRC_CPU: assert property (bus_req.wr && frc && !bus_req.from_debug |=> !force_reset)
    else $error("program write caused force reset");
  AST_FRC_DBG: assert property (bus_req.wr && frc && bus_req.from_debug && bus_req.wdata[0]
    |=> force_reset ##1 !force_reset)
    else $error("debug write gave no single force reset pulse");
  AST_ARM_START: assert property (ctl && bus_req.wdata[7:6] == 2'b11 && !secured && !arm_flag
    |=> arm_flag && fifo_count == 4'h0)
    else $error("arm start did not arm or clear count");
  AST_ARM_STOP: assert property (ctl && !bus_req.wdata[6] |=> !arm_flag)
    else $error("zero arm write did not stop run");
  AST_FULL_END: assert property (arm_flag && begin_trace && fifo_count == dct_pkg::FIFO_FULL
    |-> ##[0:1] !arm_flag)
    else $error("begin trace still armed with full buffer");
  AST_BRK_END: assert property (break_req |-> !arm_flag ##1 !break_req)
    else $error("break request while armed or longer than one cycle");
  AST_CNT_MAX: assert property (fifo_count <= dct_pkg::FIFO_FULL)
    else $error("valid count above depth");
  AST_RST_CLR: assert property ($rose(rst_b) |-> !arm_flag && fifo_count == 4'h0 && !break_req)
    else $error("state not cleared by reset");

  cover property (force_reset);
  cover property (break_req);
  cover property (fifo_count == dct_pkg::FIFO_FULL && !arm_flag);
endmodule : dct_regs_monitor

bind dct_regs dct_regs_monitor u_mon (.ref_clk, .rst_b, .bus_req, .rdata, .secured,
  .begin_trace, .force_reset, .break_req, .arm_flag, .fifo_count);

`default_nettype wire

// *** verification/dct_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module dct_cpu_model (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         run,
  input  wire logic [15:0]  base,
  input  wire logic         mon_ready,
  output dct_pkg::dct_mon_s mon,
  output logic [15:0]       opcode_addr
);
  // ****************************************
  // Bus cycle stream over eight addresses
  // ****************************************
  logic [15:0] next_addr;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      opcode_addr <= 16'h0000;
    end else begin
      opcode_addr <= opcode_addr + 16'h0003;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mon <= '0;
    end else if (!run) begin
      mon <= {1'b0, 1'b0, ~mon.addr, ~mon.data};
      next_addr <= base;
    end else if (!mon.valid || mon_ready) begin
      mon <= {1'b1, next_addr[0], next_addr, next_addr[7:0] ^ 8'h5a};
      next_addr <= {base[15:3], next_addr[2:0] + 3'h1};
    end
  end
endmodule : dct_cpu_model

`default_nettype wire

// *** verification/test_dct_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_dct_regs;
  // ****************************************
  // Bench signals and tasks
  // ****************************************
  typedef struct packed { logic [3:0] sel; logic [7:0] wd; logic [7:0] exp; } dct_row_s;
  typedef struct packed { logic [7:0] cmp; logic [7:0] ctl; logic brk; logic arm; } dct_run_s;
  localparam logic [1:0] R = 2'b00, W = 2'b01, D = 2'b11;
  logic ref_clk, rst_b, secured, event_only_mode, begin_trace, run;
  logic force_reset, break_req, break_tag, arm_flag, mon_ready;
  logic [3:0] fifo_count;
  logic [7:0] rdata, hi;
  logic [15:0] opcode_addr, cap, q[16];
  dct_pkg::dct_bus_req_s bus_req;
  dct_pkg::dct_mon_s mon;
  int miscompares, checked, n;
  dct_row_s rows[8] = '{'{4'h0, 8'h12, 8'h12}, '{4'h1, 8'h34, 8'h34}, '{4'h2, 8'h56, 8'h56},
    '{4'h3, 8'h78, 8'h78}, '{4'h4, 8'hff, 8'h00}, '{4'h5, 8'hff, 8'h00},
    '{4'h9, 8'h01, 8'h00}, '{4'h6, 8'h0f, 8'h0f}};
  dct_run_s runs[3] = '{'{8'h05, 8'hfc, 1'b1, 1'b0}, '{8'h04, 8'hdc, 1'b0, 1'b1},
    '{8'h05, 8'he0, 1'b0, 1'b0}};

  dct_regs uut (.ref_clk, .rst_b, .bus_req, .rdata, .mon, .mon_ready, .opcode_addr, .secured,
    .event_only_mode, .begin_trace, .force_reset, .break_req, .break_tag, .arm_flag, .fifo_count);
  dct_cpu_model u_cpu (.ref_clk, .rst_b, .run, .base(16'h1000), .mon_ready, .mon, .opcode_addr);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic [3:0] sel, input logic [1:0] m, input logic [7:0] wd);
    @(posedge ref_clk);
    bus_req <= {sel, m[0], !m[0], m[1], wd};
    @(posedge ref_clk);
    cap = opcode_addr;
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    #1;
  endtask : acc

  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    {rst_b, secured, event_only_mode, begin_trace, run} = '0;
    bus_req = '0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      acc(4'(i), R, 8'h00);
      chk(rdata, 8'h00);
    end
    foreach (rows[i]) begin
      acc(rows[i].sel, W, rows[i].wd);
      acc(rows[i].sel, R, 8'h00);
      chk(rdata, rows[i].exp);
    end
    acc(4'h9, W, 8'h01);
    chk(force_reset, 1'b0);
    acc(4'h9, D, 8'h01);
    chk(force_reset, 1'b1);
    acc(4'h6, W, 8'hc0);
    chk(arm_flag, 1'b1);
    acc(4'h0, W, 8'haa);
    acc(4'h0, R, 8'h00);
    chk(rdata, 8'h12);
    acc(4'h6, W, 8'h40);
    chk(arm_flag, 1'b0);
    secured <= 1'b1;
    acc(4'h6, W, 8'hc0);
    chk(arm_flag, 1'b0);
    secured <= 1'b0;
    acc(4'h6, W, 8'h00);
    for (int i = 0; i < 16; i++) begin
      acc(4'h4, R, 8'h00);
      hi = rdata;
      acc(4'h4, R, 8'h00);
      chk(rdata, hi);
      acc(4'h5, R, 8'h00);
      q[i] = cap;
      if (i >= 8) begin
        chk({hi, rdata}, q[i - 8]);
      end
    end
    acc(4'h0, W, 8'h10);
    foreach (runs[i]) begin
      acc(4'h6, W, 8'h00);
      acc(4'h1, W, runs[i].cmp);
      acc(4'h6, W, runs[i].ctl);
      run <= 1'b1;
      for (n = 0; n < 40 && break_req !== 1'b1; n++) begin
        @(posedge ref_clk);
        #1;
      end
      chk(break_req, runs[i].brk);
      chk(break_tag, runs[i].brk);
      chk(arm_flag, runs[i].arm);
      run <= 1'b0;
      if (n == 40 && runs[i].brk) begin
        summarize();
      end
    end
    event_only_mode <= 1'b1;
    begin_trace <= 1'b1;
    acc(4'h6, W, 8'h00);
    acc(4'h1, W, 8'h02);
    acc(4'h6, W, 8'hc0);
    run <= 1'b1;
    for (n = 0; n < 100 && arm_flag !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    run <= 1'b0;
    if (n == 100) begin
      miscompares++;
      $display("unexpected at %0t: begin trace never ended", $time);
      summarize();
    end
    chk(fifo_count, dct_pkg::FIFO_FULL);
    for (int i = 0; i < 8; i++) begin
      acc(4'h4, R, 8'h00);
      chk(rdata, 8'h00);
      acc(4'h5, R, 8'h00);
    end
    summarize();
  end
endmodule : test_dct_regs

`default_nettype wire
